// ===== rtl/aof_formatter.sv
`timescale 1ns/1ns
// How it works
// - 11-bit words per channel with synced clock
// - ddr or parallel chosen by standard bit
// - pin configuration uses format pin for style
// - two bits per ddr pair per sample
// - even bits on rise, odd on fall
// - ddr bit zero is a dummy bit
// - parallel mode drives whole word per cycle
// - interleaved uses first bus, parallel only
// - interleaved: second channel rise, first fall
// - interleaved tristates second channel bus
// - interleaved needs low speed, serial config
// - twos complement or offset binary selectable
// - overdrive saturates instead of wrapping
// - positive overdrive gives 7FF or 3FF
// - negative overdrive gives 000 or 400
// - power code 1111 selects interleaved mode
module aof_formatter (
  // system
  input wire logic clk,
  input wire logic rstn,
  input wire logic clkEn,
  // sample clock from outside, sampled here
  input wire logic sampleClk,
  // configuration
  input wire logic serialCfg,
  input wire logic outStdCmos,
  input wire logic dataFmtTwos,
  input wire logic formatSelectPin,
  input wire logic lowSpeed,
  input wire logic [3:0] powerStateCode,
  input wire logic [2:0] controlPinsOneToThree,
  // sample stream in
  input wire logic inValid,
  output logic inReady,
  input wire aof_pkg::aof_sample_t inA,
  input wire aof_pkg::aof_sample_t inB,
  // pins out
  output aof_pkg::aof_pins_t pins,
  output aof_pkg::aof_mode_t mode,
  output logic underrun
);

  // format one sample with saturation
  function automatic logic [10:0] fmtCode(input aof_pkg::aof_sample_t s, input logic twos);
    logic [10:0] r;
    r = s.code;
    if (s.overPos) begin
      r = twos ? aof_pkg::TC_POS_FS : aof_pkg::OB_POS_FS;
    end else if (s.overNeg) begin
      r = twos ? aof_pkg::TC_NEG_FS : aof_pkg::OB_NEG_FS;
    end else if (twos) begin
      r = s.code ^ aof_pkg::SIGN_FLIP;
    end
    return r;
  endfunction : fmtCode

  // one ddr half: even or odd bits of the word with the dummy below it
  function automatic logic [5:0] ddrHalf(input logic [10:0] w, input logic odd);
    logic [11:0] f;
    logic [5:0] r;
    f = {w, 1'b0};
    for (int k = 0; k < aof_pkg::DDR_PAIRS; k++) begin
      r[k] = f[2 * k + int'(odd)];
    end
    return r;
  endfunction : ddrHalf

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    aof_pkg::aof_pair_t buf0;
    aof_pkg::aof_pair_t buf1;
    logic [1:0] cnt;
    aof_pkg::aof_pair_t cur;
    aof_pkg::aof_pins_t pins;
    logic underrun;
  } aof_state_t;

  aof_state_t st_r;
  aof_state_t st_nxt;

  logic twosSel;
  logic cmosSel;
  logic ilvReq;
  logic ilvOn;
  logic rise;
  logic fall;
  logic bufTake;
  logic outValid;
  aof_pkg::aof_pair_t inPair;
  aof_pkg::aof_pair_t outPair;

  // mode decode from serial bits or pins
  always_comb begin
    twosSel = serialCfg ? dataFmtTwos : formatSelectPin;
    cmosSel = serialCfg ? outStdCmos : formatSelectPin;
    ilvReq = serialCfg ? (powerStateCode == aof_pkg::PWR_INTERLEAVE)
                       : (controlPinsOneToThree == aof_pkg::CTRL_INTERLEAVE);
    ilvOn = ilvReq && serialCfg && lowSpeed && cmosSel;
    if (ilvOn) begin
      mode = aof_pkg::AOF_MODE_ILV;
    end else if (cmosSel) begin
      mode = aof_pkg::AOF_MODE_PAR;
    end else begin
      mode = aof_pkg::AOF_MODE_DDR;
    end
  end

  // edges of the synchronised sample clock
  assign rise = st_r.s2 && !st_r.s3;
  assign fall = !st_r.s2 && st_r.s3;

  // two-entry buffer: count of held pairs in cnt
  assign inReady = (st_r.cnt != 2'd2);
  assign outValid = (st_r.cnt != 2'd0);
  assign bufTake = rise && outValid;
  assign outPair = st_r.buf0;
  assign inPair = '{chA: fmtCode(inA, twosSel), chB: fmtCode(inB, twosSel)};
  assign pins = st_r.pins;
  assign underrun = st_r.underrun;

  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = sampleClk;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // buffer pop then push
    if (bufTake) begin
      st_nxt.buf0 = st_r.buf1;
      st_nxt.cnt = st_r.cnt - 2'd1;
    end
    if (inValid && inReady) begin
      if (st_nxt.cnt == 2'd0) begin
        st_nxt.buf0 = inPair;
      end else begin
        st_nxt.buf1 = inPair;
      end
      st_nxt.cnt = st_nxt.cnt + 2'd1;
    end
    // both channels of one instant travel together
    if (rise) begin
      st_nxt.underrun = !outValid;
      if (outValid) begin
        st_nxt.cur = outPair;
      end
    end
    st_nxt.pins.output_clock = st_r.s2;
    st_nxt.pins.busBOe = '1;
    unique case (mode)
      aof_pkg::AOF_MODE_PAR: begin
        if (rise) begin
          st_nxt.pins.busA = outValid ? outPair.chA : st_r.cur.chA;
          st_nxt.pins.busB = outValid ? outPair.chB : st_r.cur.chB;
        end
      end
      aof_pkg::AOF_MODE_ILV: begin
        st_nxt.pins.busBOe = '0;
        st_nxt.pins.busB = aof_pkg::WORD_RST;
        if (rise) begin
          st_nxt.pins.busA = outValid ? outPair.chB : st_r.cur.chB;
        end else if (fall) begin
          st_nxt.pins.busA = st_r.cur.chA;
        end
      end
      default: begin
        // ddr: pair k holds bits 2k and 2k+1 of {word,dummy}; an underrun repeats the held word
        if (rise) begin
          st_nxt.pins.ddrA = ddrHalf(outValid ? outPair.chA : st_r.cur.chA, 1'b0);
          st_nxt.pins.ddrB = ddrHalf(outValid ? outPair.chB : st_r.cur.chB, 1'b0);
        end else if (fall) begin
          st_nxt.pins.ddrA = ddrHalf(st_r.cur.chA, 1'b1);
          st_nxt.pins.ddrB = ddrHalf(st_r.cur.chB, 1'b1);
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else if (clkEn) begin
      st_r <= st_nxt;
    end
  end

  // checks
  a_sat_pos_ob: assert property (@(posedge clk) disable iff (!rstn)
    inA.overPos && !twosSel |-> inPair.chA == aof_pkg::OB_POS_FS) else $error("pos ob");
  a_sat_pos_tc: assert property (@(posedge clk) disable iff (!rstn)
    inA.overPos && twosSel |-> inPair.chA == aof_pkg::TC_POS_FS) else $error("pos tc");
  a_sat_neg: assert property (@(posedge clk) disable iff (!rstn)
    inA.overNeg && !inA.overPos |-> inPair.chA == (twosSel ? aof_pkg::TC_NEG_FS : aof_pkg::OB_NEG_FS))
    else $error("neg sat");
  a_ilv_tristate: assert property (@(posedge clk) disable iff (!rstn)
    clkEn && mode == aof_pkg::AOF_MODE_ILV |=> pins.busBOe == '0) else $error("bus b driven");
  a_ilv_gate: assert property (@(posedge clk) disable iff (!rstn)
    !serialCfg |-> mode != aof_pkg::AOF_MODE_ILV) else $error("ilv under pins");
  sequence riseEv;
    clkEn && rise && outValid && mode == aof_pkg::AOF_MODE_PAR;
  endsequence
  a_par_word: assert property (@(posedge clk) disable iff (!rstn)
    riseEv |=> pins.busA == $past(outPair.chA)) else $error("par word");
  a_ddr_dummy: assert property (@(posedge clk) disable iff (!rstn)
    clkEn && rise && mode == aof_pkg::AOF_MODE_DDR |=> pins.ddrA[0] == 1'b0) else $error("dummy");
  a_ilv_fall: assert property (@(posedge clk) disable iff (!rstn)
    clkEn && fall && mode == aof_pkg::AOF_MODE_ILV |=> pins.busA == $past(st_r.cur.chA))
    else $error("ilv fall");
  // output clock trails the sample clock by three enabled edges
  a_clk_follow: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn, 3) && $past(clkEn) && $past(clkEn, 2) && $past(clkEn, 3) |-> pins.output_clock == $past(sampleClk, 3))
    else $error("clk out");
  a_buf_bound: assert property (@(posedge clk) disable iff (!rstn)
    st_r.cnt <= 2'd2) else $error("buffer overfill");

  // buffer count follows an accepted pair with no send, and a sent pair with no accept
  a_buf_push: assert property (@(posedge clk) disable iff (!rstn)
    clkEn && inValid && inReady && !bufTake |=> st_r.cnt == $past(st_r.cnt) + 2'd1)
    else $error("push lost");
  a_buf_pop: assert property (@(posedge clk) disable iff (!rstn)
    clkEn && bufTake && !(inValid && inReady) |=> st_r.cnt == $past(st_r.cnt) - 2'd1)
    else $error("pop lost");
  // a low enable freezes every pin
  a_freeze_pins: assert property (@(posedge clk) disable iff (!rstn)
    !clkEn |=> $stable(pins)) else $error("pins moved while frozen");

  // style and interleave decode from serial bits or pins
  a_mode_serial: assert property (@(posedge clk) disable iff (!rstn)
    serialCfg && powerStateCode != aof_pkg::PWR_INTERLEAVE
    |-> mode == (outStdCmos ? aof_pkg::AOF_MODE_PAR : aof_pkg::AOF_MODE_DDR))
    else $error("serial style");
  a_mode_pins: assert property (@(posedge clk) disable iff (!rstn)
    !serialCfg |-> mode == (formatSelectPin ? aof_pkg::AOF_MODE_PAR : aof_pkg::AOF_MODE_DDR))
    else $error("pin style");
  a_ilv_enter: assert property (@(posedge clk) disable iff (!rstn)
    serialCfg && lowSpeed && outStdCmos && powerStateCode == aof_pkg::PWR_INTERLEAVE
    |-> mode == aof_pkg::AOF_MODE_ILV) else $error("ilv not entered");
  a_ilv_cmos: assert property (@(posedge clk) disable iff (!rstn)
    mode == aof_pkg::AOF_MODE_ILV |-> outStdCmos && lowSpeed) else $error("ilv without cmos");

  // plain codes: offset binary passes, twos complement flips the top bit
  a_fmt_plain: assert property (@(posedge clk) disable iff (!rstn)
    !inA.overPos && !inA.overNeg
    |-> inPair.chA[9:0] == inA.code[9:0] && inPair.chA[10] == (inA.code[10] ^ twosSel))
    else $error("number format");
  a_sat_b: assert property (@(posedge clk) disable iff (!rstn)
    inB.overPos || inB.overNeg
    |-> inPair.chB == (inB.overPos ? (twosSel ? aof_pkg::TC_POS_FS : aof_pkg::OB_POS_FS)
                                   : (twosSel ? aof_pkg::TC_NEG_FS : aof_pkg::OB_NEG_FS)))
    else $error("b saturation");

  // ddr halves: even bits after a rise, odd bits after a fall
  sequence ddrRise;
    clkEn && rise && outValid && mode == aof_pkg::AOF_MODE_DDR;
  endsequence
  sequence ddrFall;
    clkEn && fall && mode == aof_pkg::AOF_MODE_DDR;
  endsequence
  a_ddr_even_a: assert property (@(posedge clk) disable iff (!rstn)
    ddrRise |=> pins.ddrA[5:1] == {$past(outPair.chA[9]), $past(outPair.chA[7]), $past(outPair.chA[5]),
                                   $past(outPair.chA[3]), $past(outPair.chA[1])})
    else $error("ddr a even");
  a_ddr_even_b: assert property (@(posedge clk) disable iff (!rstn)
    ddrRise |=> pins.ddrB[5:1] == {$past(outPair.chB[9]), $past(outPair.chB[7]), $past(outPair.chB[5]),
                                   $past(outPair.chB[3]), $past(outPair.chB[1])})
    else $error("ddr b even");
  a_ddr_odd_a: assert property (@(posedge clk) disable iff (!rstn)
    ddrFall |=> pins.ddrA == {$past(st_r.cur.chA[10]), $past(st_r.cur.chA[8]), $past(st_r.cur.chA[6]),
                              $past(st_r.cur.chA[4]), $past(st_r.cur.chA[2]), $past(st_r.cur.chA[0])})
    else $error("ddr a odd");
  a_ddr_odd_b: assert property (@(posedge clk) disable iff (!rstn)
    ddrFall |=> pins.ddrB == {$past(st_r.cur.chB[10]), $past(st_r.cur.chB[8]), $past(st_r.cur.chB[6]),
                              $past(st_r.cur.chB[4]), $past(st_r.cur.chB[2]), $past(st_r.cur.chB[0])})
    else $error("ddr b odd");

  // interleave: second channel after a rise, first after a fall
  sequence ilvRise;
    clkEn && rise && outValid && mode == aof_pkg::AOF_MODE_ILV;
  endsequence
  a_ilv_rise: assert property (@(posedge clk) disable iff (!rstn)
    ilvRise |=> pins.busA == $past(outPair.chB)) else $error("ilv rise");

  // parallel: second bus carries its own word and stays driven
  a_par_busb: assert property (@(posedge clk) disable iff (!rstn)
    riseEv |=> pins.busB == $past(outPair.chB)) else $error("par bus b");
  a_busb_driven: assert property (@(posedge clk) disable iff (!rstn)
    clkEn && mode != aof_pkg::AOF_MODE_ILV |=> pins.busBOe == '1)
    else $error("bus b released");
  a_par_hold: assert property (@(posedge clk) disable iff (!rstn)
    clkEn && !rise && mode == aof_pkg::AOF_MODE_PAR |=> $stable(pins.busA))
    else $error("par word moved");
  // an empty buffer at a sample clock rise raises underrun
  a_underrun_set: assert property (@(posedge clk) disable iff (!rstn)
    clkEn && rise && !outValid |=> underrun) else $error("underrun missed");
endmodule : aof_formatter

// ===== rtl/aof_pkg.sv
package aof_pkg;
  // sample and output widths
  localparam int SAMPLE_W = 11;
  localparam int DDR_PAIRS = 6;
  // saturation codes per format
  localparam logic [10:0] OB_POS_FS = 11'h7FF;
  localparam logic [10:0] OB_NEG_FS = 11'h000;
  localparam logic [10:0] TC_POS_FS = 11'h3FF;
  localparam logic [10:0] TC_NEG_FS = 11'h400;
  // offset binary to twos complement flips the top bit
  localparam logic [10:0] SIGN_FLIP = 11'h400;
  // power state code that selects interleaved output
  localparam logic [3:0] PWR_INTERLEAVE = 4'hF;
  localparam logic [3:0] PWR_NORMAL = 4'h0;
  // control pin pattern requesting interleave; it never selects interleaved output, which needs serial config
  localparam logic [2:0] CTRL_INTERLEAVE = 3'h7;
  // reset values
  localparam logic [10:0] WORD_RST = 11'h000;
  localparam logic [1:0] CNT_RST = 2'h0;
  // link clock at 160 ns against a 20 ns system clock
  localparam int LINK_PERIOD_NS = 160;
  localparam int CLK_PERIOD_NS = 20;
  localparam int LINK_CYCLES = LINK_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    AOF_MODE_DDR = 2'b00,
    AOF_MODE_PAR = 2'b01,
    AOF_MODE_ILV = 2'b10
  } aof_mode_t;

  // one sample from the converter core
  typedef struct packed {
    logic [10:0] code;
    logic overPos;
    logic overNeg;
  } aof_sample_t;

  // a pair of channel samples taken at one instant
  typedef struct packed {
    logic [10:0] chA;
    logic [10:0] chB;
  } aof_pair_t;

  // output pin group
  typedef struct packed {
    logic [10:0] busA;
    logic [10:0] busB;
    logic [10:0] busBOe;
    logic [5:0] ddrA;
    logic [5:0] ddrB;
    logic output_clock;
  } aof_pins_t;
endpackage : aof_pkg

// ===== verification/aof_receiver.sv
`timescale 1ns/1ns
module aof_receiver (
  // system
  input wire logic clk,
  // device pins
  input wire aof_pkg::aof_pins_t pins,
  // captured frame
  output logic frameStb,
  output aof_pkg::aof_pins_t riseP,
  output aof_pkg::aof_pins_t fallP,
  output logic [10:0] ddrWordA,
  output logic [10:0] ddrWordB
);
  logic prevClk;
  logic [11:0] wA;
  logic [11:0] wB;
  // capture the pins on both output clock edges, frame ends on fall
  always_ff @(posedge clk) begin
    prevClk <= pins.output_clock;
    frameStb <= prevClk && !pins.output_clock;
    if (pins.output_clock && !prevClk) begin
      riseP <= pins;
    end
    if (!pins.output_clock && prevClk) begin
      fallP <= pins;
    end
  end
  // rebuild ddr words, even bits from rise and odd from fall
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      wA[2*k] = riseP.ddrA[k];
      wA[2*k+1] = fallP.ddrA[k];
      wB[2*k] = riseP.ddrB[k];
      wB[2*k+1] = fallP.ddrB[k];
    end
    ddrWordA = wA[11:1];
    ddrWordB = wB[11:1];
  end
endmodule : aof_receiver

// ===== verification/tb.sv
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0, rstn = 1'b0, sampleClk = 1'b0, inValid = 1'b0, serialCfg = 1'b0;
  logic outStdCmos = 1'b0, dataFmtTwos = 1'b0, formatSelectPin = 1'b0, lowSpeed = 1'b0;
  logic clkEn = 1'b1;
  logic [3:0] powerStateCode = 4'h0;
  logic [2:0] controlPinsOneToThree = 3'h0;
  aof_pkg::aof_sample_t inA = '0, inB = '0;
  aof_pkg::aof_pins_t pins, riseP, fallP, held;
  aof_pkg::aof_mode_t mode;
  logic inReady, underrun, frameStb;
  logic [10:0] ddrWordA, ddrWordB;
  int num_errors = 0, checks_done = 0, twos, ilv, par, ea, eb, expA[$], expB[$];
  logic [4:0] cfgT [6] = '{5'h10, 5'h1C, 5'h1D, 5'h03, 5'h0C, 5'h18};
  int modeT [6] = '{0, 1, 2, 1, 0, 1};
  int twosT [6] = '{0, 1, 1, 1, 0, 0};
  // clocks
  always #10 clk = ~clk;
  always #80 sampleClk = ~sampleClk;
  aof_formatter uut (.clk, .rstn, .clkEn, .sampleClk, .serialCfg, .outStdCmos, .dataFmtTwos,
    .formatSelectPin, .lowSpeed, .powerStateCode, .controlPinsOneToThree, .inValid, .inReady,
    .inA, .inB, .pins, .mode, .underrun);
  aof_receiver rx (.clk, .pins, .frameStb, .riseP, .fallP, .ddrWordA, .ddrWordB);
  // reference formatting of one sample
  function automatic int fmt(aof_pkg::aof_sample_t s, int t);
    if (s.overPos) return t ? 11'h3FF : 11'h7FF;
    if (s.overNeg) return t ? 11'h400 : 11'h000;
    return t ? (s.code ^ 11'h400) : s.code;
  endfunction : fmt
  function automatic aof_pkg::aof_sample_t rnd();
    aof_pkg::aof_sample_t s;
    int r;
    r = $urandom % 6;
    s.code = 11'($urandom);
    s.overPos = (r == 0);
    s.overNeg = (r == 1);
    return s;
  endfunction : rnd
  task automatic chk(logic [10:0] got, int exp);
    checks_done++;
    if (got !== exp[10:0]) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp[10:0]);
    end
  endtask : chk
  task automatic end_sim;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  // compare each completed frame without underrun with the model queue
  always @(negedge clk) begin
    if (frameStb && !underrun && expA.size() > 0) begin
      ea = expA.pop_front();
      eb = expB.pop_front();
      if (ilv) begin
        chk(riseP.busA, eb);
        chk(fallP.busA, ea);
        chk(riseP.busBOe, 0);
      end else if (par) begin
        chk(riseP.busA, ea);
        chk(riseP.busB, eb);
        chk(riseP.busBOe, 11'h7FF);
      end else begin
        chk(ddrWordA, ea);
        chk(ddrWordB, eb);
      end
    end
  end
  // watchdog
  initial begin
    #100000;
    num_errors++;
    end_sim;
  end
  // each configuration: reset, check mode, stream pairs back to back
  initial begin
    void'($urandom(78));
    for (int c = 0; c < 6; c++) begin
      @(negedge clk);
      rstn = 1'b0;
      expA.delete();
      expB.delete();
      {serialCfg, outStdCmos, dataFmtTwos, formatSelectPin, lowSpeed} = cfgT[c];
      powerStateCode = (c == 2 || c == 5) ? 4'hF : 4'h0;
      controlPinsOneToThree = (c == 3) ? 3'h7 : 3'h0;
      twos = twosT[c];
      ilv = (modeT[c] == 2);
      par = (modeT[c] == 1);
      repeat (3) @(negedge clk);
      rstn = 1'b1;
      chk({9'h000, mode}, modeT[c]);
      for (int i = 0; i < 12; i++) begin
        @(negedge clk);
        inA = rnd();
        inB = rnd();
        inValid = 1'b1;
        #1;
        while (inReady !== 1'b1) begin
          @(negedge clk);
          #1;
        end
        expA.push_back(fmt(inA, twos));
        expB.push_back(fmt(inB, twos));
      end
      @(negedge clk);
      inValid = 1'b0;
      repeat (60) @(negedge clk);
      chk(11'(expA.size()), 0);
      chk({10'h000, underrun}, 1);
      held = pins;
      clkEn = 1'b0;
      repeat (6) @(negedge clk);
      chk({10'h000, pins !== held}, 0);
      clkEn = 1'b1;
    end
    end_sim;
  end
endmodule : tb
